// file: ftss_sensor.sv
// sensor end: apb registers, frame/row timing and slave-mode trigger logic
//
// Contract
// - vertical binning combines two or three rows
// - horizontal binning combines two or three pixels
// - skip by two or three, columns and rows
// - column skip keeps row time; row skip shortens frame
// - frame is rows times row clocks plus extra
// - row lasts row clocks; two pixels per clock
// - row clocks meet the three minimum limits
// - frame rows cover height plus minimum blanking
// - blanking: black, embedded, blank, idle rows
// - hdr: add idle rows for second exposure
// - embed bit picks data rows or blank rows
// - black-row select sets 8, 4 or 2
// - asic holds pulse three clocks or more
// - slave starts frame on edge when active
// - inactive one frame plus sixteen clocks
// - edge while inactive is ignored
// - free-running frames restart after extra delay
// - slave wait halts read and shutter
// - wait: read row zero, shutter holds
// - pulse spacing exceeds configured frame period
// - standby, slave, trigger enable, then streaming
// - standby after frame; not while trigger high
// - writes in frame n apply at n+2; width and skip factors take effect at once here
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ftss_sensor
  import ftss_pkg::*;
#(
  parameter int CNT_W = 16 // width of row and clock counters
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  ftss_link_if.sensor      link,
  // readout strobes
  output logic             row_read_q,     // one-cycle pulse per read row
  output logic             row_reset_q,    // one-cycle pulse per shutter row
  output logic [CNT_W-1:0] read_ptr_q,     // row being read
  output logic [CNT_W-1:0] shut_ptr_q,     // row being reset
  output logic             line_valid_q,   // active pixel row
  output logic             embed_row_q,    // embedded data row in progress
  output logic             ob_row_q,       // optically black row in progress
  output logic [1:0]       row_group_q,    // rows binned together minus one
  output logic [1:0]       pix_group_q,    // pixels binned together minus one
  output logic             min_viol_q      // configuration below a limit
);
  // shadow (written) and active (in use) configuration
  logic [2:0]       ctrl_q;
  logic [CNT_W-1:0] rowclk_w_q, frmrow_w_q, extra_w_q, width_w_q, height_w_q;
  logic [7:0]       subs_w_q;
  logic [23:0]      blank_w_q;
  logic [CNT_W-1:0] rowclk_p_q, frmrow_p_q, extra_p_q; // pending stage
  logic [7:0]       subs_p_q;
  logic [23:0]      blank_p_q;
  logic [CNT_W-1:0] rowclk_q, frmrow_q, extra_q;     // active stage
  logic [7:0]       subs_q;
  logic [23:0]      blank_q;
  // sequencer
  ftss_state_t      state_q;
  logic [CNT_W-1:0] clk_cnt_q;   // clocks within row or extra delay
  logic [CNT_W-1:0] row_cnt_q;   // row within frame
  logic [31:0]      inact_q;     // slave inactive countdown
  logic             vd_s1_q, vd_s2_q, vd_s3_q; // synchroniser and edge
  logic             vd_rise;
  logic             apb_acc;
  logic             frame_start, frame_end;
  logic [CNT_W-1:0] vb_rows, ob_rows, eff_rows, lim_a, lim_b, row_step, col_step;
  logic [31:0]      frame_len;

  assign apb_acc = psel && penable;

  // apb writes land in the shadow set; one-cycle answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= 3'h0;
      rowclk_w_q <= FTSS_RST_ROWCLK;
      frmrow_w_q <= FTSS_RST_FRMROW;
      extra_w_q  <= FTSS_RST_EXTRA;
      width_w_q  <= FTSS_RST_WIDTH;
      height_w_q <= FTSS_RST_HEIGHT;
      subs_w_q   <= 8'h00;
      blank_w_q  <= {FTSS_IDLE_MIN, 7'h00, 1'b1, FTSS_OB_8, 4'h0};
    end else if (apb_acc && pwrite) begin
      case (paddr)
        FTSS_OFF_CTRL:   ctrl_q     <= pwdata[2:0];
        FTSS_OFF_ROWCLK: rowclk_w_q <= pwdata[CNT_W-1:0];
        FTSS_OFF_FRMROW: frmrow_w_q <= pwdata[CNT_W-1:0];
        FTSS_OFF_EXTRA:  extra_w_q  <= pwdata[CNT_W-1:0];
        FTSS_OFF_WIDTH:  width_w_q  <= pwdata[CNT_W-1:0];
        FTSS_OFF_HEIGHT: height_w_q <= pwdata[CNT_W-1:0];
        FTSS_OFF_SUBS:   subs_w_q   <= pwdata[7:0];
        FTSS_OFF_BLANK:  blank_w_q  <= pwdata[23:0];
        default: ;       // unmapped or read-only: ignored; error flagged for unmapped only
      endcase
    end
  end

  // apb read mux and answer flags, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;  // ready in the first access cycle
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          FTSS_OFF_CTRL:   prdata <= {29'h0, ctrl_q};
          FTSS_OFF_ROWCLK: prdata <= {16'h0, rowclk_w_q};
          FTSS_OFF_FRMROW: prdata <= {16'h0, frmrow_w_q};
          FTSS_OFF_EXTRA:  prdata <= {16'h0, extra_w_q};
          FTSS_OFF_WIDTH:  prdata <= {16'h0, width_w_q};
          FTSS_OFF_HEIGHT: prdata <= {16'h0, height_w_q};
          FTSS_OFF_SUBS:   prdata <= {24'h0, subs_w_q};
          FTSS_OFF_BLANK:  prdata <= {8'h0, blank_w_q};
          FTSS_OFF_STATUS: prdata <= {row_cnt_q, 11'h0, min_viol_q, state_q};
          default:         pslverr <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  // two-stage pipeline: a write during frame n reaches pending at frame
  // n+1 start and active at frame n+2 start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rowclk_p_q <= FTSS_RST_ROWCLK;
      frmrow_p_q <= FTSS_RST_FRMROW;
      extra_p_q  <= FTSS_RST_EXTRA;
      subs_p_q   <= 8'h00;
      blank_p_q  <= {FTSS_IDLE_MIN, 7'h00, 1'b1, FTSS_OB_8, 4'h0};
      rowclk_q   <= FTSS_RST_ROWCLK;
      frmrow_q   <= FTSS_RST_FRMROW;
      extra_q    <= FTSS_RST_EXTRA;
      subs_q     <= 8'h00;
      blank_q    <= {FTSS_IDLE_MIN, 7'h00, 1'b1, FTSS_OB_8, 4'h0};
    end else if (frame_start || state_q == FTSS_ST_STBY) begin
      // in standby both stages follow at once so streaming starts fresh
      rowclk_p_q <= rowclk_w_q;
      frmrow_p_q <= frmrow_w_q;
      extra_p_q  <= extra_w_q;
      subs_p_q   <= subs_w_q;
      blank_p_q  <= blank_w_q;
      rowclk_q   <= (state_q == FTSS_ST_STBY) ? rowclk_w_q : rowclk_p_q;
      frmrow_q   <= (state_q == FTSS_ST_STBY) ? frmrow_w_q : frmrow_p_q;
      extra_q    <= (state_q == FTSS_ST_STBY) ? extra_w_q : extra_p_q;
      subs_q     <= (state_q == FTSS_ST_STBY) ? subs_w_q : subs_p_q;
      blank_q    <= (state_q == FTSS_ST_STBY) ? blank_w_q : blank_p_q;
    end
  end

  // black rows from the four-bit select; unknown codes fall back to 8
  always_comb begin
    case (blank_q[FTSS_BLANK_OBSEL +: 4])
      FTSS_OB_4: ob_rows = CNT_W'(4);
      FTSS_OB_2: ob_rows = CNT_W'(2);
      default:   ob_rows = CNT_W'(8);
    endcase
  end

  // blanking = black + embedded/blank pair + blank pair + idle
  assign vb_rows = ob_rows + CNT_W'(FTSS_EMBED_ROWS) + CNT_W'(FTSS_BLANK_ROWS)
                 + CNT_W'(blank_q[FTSS_BLANK_IDLE +: 8]);

  // subsampling step factors (0 read as 1)
  assign col_step = (subs_w_q[FTSS_SUBS_COLSKIP +: 2] == 2'd0) ? CNT_W'(1)
                  : CNT_W'(subs_w_q[FTSS_SUBS_COLSKIP +: 2]);
  assign row_step = (subs_w_q[FTSS_SUBS_ROWSKIP +: 2] == 2'd0) ? CNT_W'(1)
                  : CNT_W'(subs_w_q[FTSS_SUBS_ROWSKIP +: 2]);
  // pixel pairs per row at two per clock; limits per row
  assign lim_a    = CNT_W'(width_w_q / col_step / 3);
  assign lim_b    = CNT_W'(width_w_q / col_step / 2 + 96);
  assign eff_rows = CNT_W'(height_w_q / row_step); // row skip shrinks rows

  // flag a shadow configuration below any documented minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_viol_q <= 1'b0;
    end else begin
      min_viol_q <= (rowclk_w_q < CNT_W'(1100)) || (rowclk_w_q < lim_a)
                 || (rowclk_w_q < lim_b) || (frmrow_w_q < eff_rows + vb_rows);
    end
  end

  // binning groups go out with the active set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_group_q <= 2'd0;
      pix_group_q <= 2'd0;
    end else begin
      row_group_q <= (subs_q[FTSS_SUBS_VBIN +: 2] >= 2'd2)
                   ? subs_q[FTSS_SUBS_VBIN +: 2] - 2'd1 : 2'd0;
      pix_group_q <= (subs_q[FTSS_SUBS_HBIN +: 2] >= 2'd2)
                   ? subs_q[FTSS_SUBS_HBIN +: 2] - 2'd1 : 2'd0;
    end
  end

  // trigger synchroniser; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vd_s1_q <= 1'b0;
      vd_s2_q <= 1'b0;
      vd_s3_q <= 1'b0;
    end else begin
      vd_s1_q <= link.vertical_drive_pulse;
      vd_s2_q <= vd_s1_q;
      vd_s3_q <= vd_s2_q;
    end
  end
  assign vd_rise = vd_s2_q && !vd_s3_q && ctrl_q[FTSS_CTRL_TRIGEN];

  // frame length in clocks
  assign frame_len = 32'(frmrow_q) * 32'(rowclk_q) + 32'(extra_q);
  // extra delay lasts exactly extra_q clocks; a zero setting still costs one clock
  assign frame_end = (state_q == FTSS_ST_XTRA) && (clk_cnt_q + CNT_W'(1) >= extra_q);
  assign frame_start = (state_q == FTSS_ST_WAIT && vd_rise && inact_q == 32'd0)
                    || (frame_end && ctrl_q[FTSS_CTRL_STREAM] && !ctrl_q[FTSS_CTRL_SLAVE]);

  // frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= FTSS_ST_STBY;
      clk_cnt_q <= '0;
      row_cnt_q <= '0;
    end else begin
      case (state_q)
        FTSS_ST_STBY: begin
          clk_cnt_q <= '0;
          row_cnt_q <= '0;
          if (ctrl_q[FTSS_CTRL_STREAM] || vd_s2_q) begin
            state_q <= ctrl_q[FTSS_CTRL_SLAVE] ? FTSS_ST_WAIT : FTSS_ST_ROWS;
          end
        end
        FTSS_ST_WAIT: begin
          clk_cnt_q <= '0;                 // sequencing halted
          row_cnt_q <= '0;
          if (!ctrl_q[FTSS_CTRL_STREAM] && !vd_s2_q) begin
            state_q <= FTSS_ST_STBY;
          end else if (frame_start) begin
            state_q <= FTSS_ST_ROWS;
          end
        end
        FTSS_ST_ROWS: begin
          if (clk_cnt_q >= rowclk_q - CNT_W'(1)) begin // row of rowclk clocks
            clk_cnt_q <= '0;
            if (row_cnt_q >= frmrow_q - CNT_W'(1)) begin
              row_cnt_q <= '0;
              state_q   <= FTSS_ST_XTRA;
            end else begin
              row_cnt_q <= row_cnt_q + CNT_W'(1);
            end
          end else begin
            clk_cnt_q <= clk_cnt_q + CNT_W'(1);
          end
        end
        FTSS_ST_XTRA: begin
          clk_cnt_q <= clk_cnt_q + CNT_W'(1);
          if (frame_end) begin
            clk_cnt_q <= '0;
            // standby only at frame end and only with trigger low
            if (!ctrl_q[FTSS_CTRL_STREAM] && !vd_s2_q) begin
              state_q <= FTSS_ST_STBY;
            end else if (ctrl_q[FTSS_CTRL_SLAVE]) begin
              state_q <= FTSS_ST_WAIT;
            end else begin
              state_q <= FTSS_ST_ROWS;     // next frame at once
            end
          end
        end
        default: state_q <= FTSS_ST_STBY;
      endcase
    end
  end

  // slave inactive window: frame plus tail; edges meanwhile dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inact_q <= 32'd0;
    end else if (state_q == FTSS_ST_WAIT && vd_rise && inact_q == 32'd0) begin
      inact_q <= frame_len + 32'(FTSS_SLAVE_TAIL) - 32'd1;
    end else if (inact_q != 32'd0) begin
      inact_q <= inact_q - 32'd1;
    end
  end

  // row strobes and pointers; wait pins read at 0, shutter held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_read_q   <= 1'b0;
      row_reset_q  <= 1'b0;
      read_ptr_q   <= '0;
      shut_ptr_q   <= '0;
      line_valid_q <= 1'b0;
      embed_row_q  <= 1'b0;
      ob_row_q     <= 1'b0;
    end else begin
      row_read_q  <= (state_q == FTSS_ST_ROWS) && (clk_cnt_q == '0);
      row_reset_q <= (state_q == FTSS_ST_ROWS) && (clk_cnt_q == '0);
      if (state_q == FTSS_ST_ROWS) begin
        read_ptr_q <= row_cnt_q;
        if (clk_cnt_q == '0) begin
          shut_ptr_q <= (shut_ptr_q >= frmrow_q - CNT_W'(1)) ? '0
                      : shut_ptr_q + CNT_W'(1);
        end
      end else if (state_q == FTSS_ST_WAIT) begin
        read_ptr_q <= '0;
      end
      // frame starts with blanking: black, embedded-or-blank, blank, idle
      ob_row_q     <= (state_q == FTSS_ST_ROWS) && (row_cnt_q < ob_rows);
      embed_row_q  <= (state_q == FTSS_ST_ROWS) && blank_q[FTSS_BLANK_EMBED]
                   && (row_cnt_q >= ob_rows)
                   && (row_cnt_q < ob_rows + CNT_W'(FTSS_EMBED_ROWS));
      line_valid_q <= (state_q == FTSS_ST_ROWS) && (row_cnt_q >= vb_rows)
                   && (clk_cnt_q < CNT_W'(width_w_q / col_step / 2));
    end
  end

  // frame activity reported back over the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.frame_active <= 1'b0;
    end else begin
      link.frame_active <= (state_q == FTSS_ST_ROWS) || (state_q == FTSS_ST_XTRA);
    end
  end
endmodule : ftss_sensor
`default_nettype wire

// file: ftss_pkg.sv
// package: constants and types shared by the frame timing block and its driver
package ftss_pkg;
  // register word offsets of the sensor-side apb slave
  localparam logic [7:0] FTSS_OFF_CTRL    = 8'h00; // streaming, trigger enable, slave enable
  localparam logic [7:0] FTSS_OFF_ROWCLK  = 8'h04; // row_clock_count
  localparam logic [7:0] FTSS_OFF_FRMROW  = 8'h08; // frame_row_count
  localparam logic [7:0] FTSS_OFF_EXTRA   = 8'h0C; // frame_extra_delay
  localparam logic [7:0] FTSS_OFF_WIDTH   = 8'h10; // window width in pixels
  localparam logic [7:0] FTSS_OFF_HEIGHT  = 8'h14; // window height in rows
  localparam logic [7:0] FTSS_OFF_SUBS    = 8'h18; // bin and skip factors
  localparam logic [7:0] FTSS_OFF_BLANK   = 8'h1C; // black rows, embedded, idle rows
  localparam logic [7:0] FTSS_OFF_STATUS  = 8'h20; // read-only state
  // control field positions
  localparam int FTSS_CTRL_STREAM  = 0;
  localparam int FTSS_CTRL_TRIGEN  = 1;
  localparam int FTSS_CTRL_SLAVE   = 2;
  // subsampling field positions: each factor is 1, 2 or 3
  localparam int FTSS_SUBS_COLSKIP = 0;
  localparam int FTSS_SUBS_ROWSKIP = 2;
  localparam int FTSS_SUBS_HBIN    = 4;
  localparam int FTSS_SUBS_VBIN    = 6;
  // blanking field positions
  localparam int FTSS_BLANK_OBSEL  = 4; // four-bit black-row select
  localparam int FTSS_BLANK_EMBED  = 8; // 1: embedded rows, 0: blank rows
  localparam int FTSS_BLANK_IDLE   = 16; // idle rows field, 8 bits
  // reset values
  localparam logic [15:0] FTSS_RST_ROWCLK = 16'h044C; // 1100 clocks
  localparam logic [15:0] FTSS_RST_FRMROW = 16'h0460; // 1120 rows
  localparam logic [15:0] FTSS_RST_EXTRA  = 16'h0000;
  localparam logic [15:0] FTSS_RST_WIDTH  = 16'h0800;
  localparam logic [15:0] FTSS_RST_HEIGHT = 16'h0440;
  localparam logic [3:0]  FTSS_OB_8       = 4'h8;
  localparam logic [3:0]  FTSS_OB_4       = 4'h4;
  localparam logic [3:0]  FTSS_OB_2       = 4'h2;
  localparam logic [7:0]  FTSS_IDLE_MIN   = 8'h04;
  localparam logic [1:0]  FTSS_EMBED_ROWS = 2'h2;
  localparam logic [1:0]  FTSS_BLANK_ROWS = 2'h2;
  // timing
  localparam int FTSS_SLAVE_TAIL  = 16; // clocks added to inactive time
  localparam int FTSS_PULSE_MIN   = 3;  // least pulse width, clocks
  // frame sequencer states
  typedef enum logic [3:0] {
    FTSS_ST_STBY = 4'b0001, // soft standby
    FTSS_ST_WAIT = 4'b0010, // slave wait, sequencing halted
    FTSS_ST_ROWS = 4'b0100, // reading rows
    FTSS_ST_XTRA = 4'b1000  // extra delay at frame end
  } ftss_state_t;
endpackage : ftss_pkg

// file: ftss_link_if.sv
// interface: vertical-drive link between the host asic and the sensor timing block
`timescale 1ns/1ps
`default_nettype none
interface ftss_link_if;
  logic vertical_drive_pulse; // trigger input level, active high
  logic frame_active;         // sensor reports frame readout in progress
  modport sensor (input vertical_drive_pulse, output frame_active);
  modport asic   (output vertical_drive_pulse, input frame_active);
endinterface : ftss_link_if
`default_nettype wire

// file: ftss_asic.sv
// asic end: generates vertical-drive pulses at a programmed spacing
`timescale 1ns/1ps
`default_nettype none
module ftss_asic
  import ftss_pkg::*;
#(
  parameter int PER_W = 32 // width of the pulse period counter
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // user side
  input  wire logic             run,        // level: emit pulses while high
  input  wire logic [PER_W-1:0] period,     // clocks between rising edges
  input  wire logic [7:0]       width,      // pulse width in clocks
  output logic                  pulse_sent_q, // one-cycle pulse per rising edge
  output logic                  frame_seen_q, // registered frame_active
  // link
  ftss_link_if.asic             link
);
  logic [PER_W-1:0] cnt_q;  // clocks since last rising edge
  logic [7:0]       wid_eff; // width clamped to the least allowed

  // never shorter than three clocks
  assign wid_eff = (width < 8'(FTSS_PULSE_MIN)) ? 8'(FTSS_PULSE_MIN) : width;

  // period counter; the user keeps period above the frame period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (cnt_q >= period - PER_W'(1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end

  // drive the pulse high for wid_eff clocks from each period start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.vertical_drive_pulse <= 1'b0;
      pulse_sent_q              <= 1'b0;
      frame_seen_q              <= 1'b0;
    end else begin
      link.vertical_drive_pulse <= run && (cnt_q < PER_W'(wid_eff));
      pulse_sent_q              <= run && (cnt_q == '0);
      frame_seen_q              <= link.frame_active;
    end
  end
endmodule : ftss_asic
`default_nettype wire

// file: ftss_link_chk.sv
// checker: trigger and frame timing seen on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ftss_link_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic vertical_drive_pulse,
  input wire logic frame_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] low_q;   // cycles frame_active has stayed low
  logic [7:0] since_q; // cycles since the last trigger rise
  logic       seen_q;  // a frame has ended, so starts are trigger-led
  logic       vd_q;    // trigger rose while no frame ran
  // counters saturate so long standby waits cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 8'h00;
    else if (frame_active) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end
  // age of the newest trigger edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_q <= 8'hFF;
    else if ($rose(vertical_drive_pulse)) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end
  // free-running start after reset is not trigger-led, hence the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_q <= 1'b0;
    else if ($fell(frame_active)) seen_q <= 1'b1;
  end
  // edge candidate between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vd_q <= 1'b0;
    else if (frame_active) vd_q <= 1'b0;
    else if ($rose(vertical_drive_pulse)) vd_q <= 1'b1;
  end
  sequence s_vd_rise;
    $rose(vertical_drive_pulse);
  endsequence
  sequence s_quiet;
    !frame_active[*8] ##1 !frame_active[*6];
  endsequence
  AST_PULSE_WIDTH: assert property (s_vd_rise |-> vertical_drive_pulse[*3])
    else $error("trigger pulse shorter than three clocks");
  AST_PULSE_LOW: assert property ($fell(vertical_drive_pulse) |-> !vertical_drive_pulse[*2])
    else $error("trigger low phase too short");
  AST_SYNC_DELAY: assert property (s_vd_rise |-> ##1 (!$rose(frame_active))[*2])
    else $error("frame started before trigger was synchronised");
  AST_ACCEPT: assert property (s_vd_rise and (!frame_active && low_q > 8'h14 && seen_q)
    |-> ##[2:6] $rose(frame_active))
    else $error("trigger in active wait did not start a frame");
  AST_LATENCY: assert property ($rose(frame_active) && seen_q
    |-> since_q >= 8'h01 && since_q <= 8'h06)
    else $error("frame start not tied to a recent trigger");
  AST_CAUSE: assert property ($rose(frame_active) && seen_q |-> vd_q)
    else $error("frame started without a fresh trigger edge");
  AST_REARM: assert property ($fell(frame_active) |-> s_quiet)
    else $error("frame restarted inside the inactive window");
  AST_FRAME_MIN: assert property ($rose(frame_active) |-> frame_active[*8])
    else $error("frame shorter than eight clocks");
endmodule : ftss_link_chk
`default_nettype wire

// file: tb_top.sv
// testbench: both link ends, apb register traffic and a frame timing model
`timescale 1ns/1ps
`default_nettype none
module tb_top import ftss_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, re, run, rr, rs, ob, emb, mv, lv;
  int          lv_c, lv_l;
  logic [7:0]  paddr, width;
  logic [31:0] pwdata, prdata, rq, period;
  logic        pready, pslverr;
  logic [15:0] rptr, sptr;
  logic [1:0]  rgrp, pgrp;
  int          failures, checks, cyc, nfr, st, lr, rows_c, rows_l, per_l, ob_c, ob_l;
  int          emb_c, emb_l, tot, rc, fr, ex, i, k, e, vb, hb, s0, sp;
  int          obq[$] = '{8, 4, 2};
  logic [7:0]  offs [7] = '{FTSS_OFF_CTRL, FTSS_OFF_ROWCLK, FTSS_OFF_FRMROW, FTSS_OFF_EXTRA,
                            FTSS_OFF_WIDTH, FTSS_OFF_HEIGHT, FTSS_OFF_BLANK};
  logic [31:0] rsts [7] = '{32'h0000_0000, 32'h0000_044C, 32'h0000_0460, 32'h0000_0000,
                            32'h0000_0800, 32'h0000_0440, 32'h0004_0180};
  ftss_link_if u_link ();
  ftss_sensor u_ftss_sensor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_link), .row_read_q(rr), .row_reset_q(rs), .read_ptr_q(rptr),
    .shut_ptr_q(sptr), .line_valid_q(lv), .embed_row_q(emb), .ob_row_q(ob),
    .row_group_q(rgrp), .pix_group_q(pgrp), .min_viol_q(mv));
  ftss_asic u_ftss_asic (.pclk(pclk), .presetn(presetn), .run(run), .period(period),
    .width(width), .pulse_sent_q(), .frame_seen_q(), .link(u_link));
  ftss_link_chk u_ftss_link_chk (.pclk(pclk), .presetn(presetn),
    .vertical_drive_pulse(u_link.vertical_drive_pulse), .frame_active(u_link.frame_active));
  // free-running clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // frame monitor: period, rows and row kinds of each finished frame
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (ob === 1'b1) ob_c = ob_c + 1;
    if (emb === 1'b1) emb_c = emb_c + 1;
    if (lv === 1'b1) lv_c = lv_c + 1;
    if (rs === 1'b1) tot = tot + 1;
    if (rr === 1'b1) begin
      tot = tot + 1;
      rows_c = rows_c + 1;
      if (rptr === 16'h0000) begin
        per_l = cyc - st;
        rows_l = rows_c - 1;
        ob_l = ob_c;
        emb_l = emb_c;
        lv_l = lv_c;
        lv_c = 0;
        st = cyc;
        rows_c = 1;
        ob_c = 0;
        emb_c = 0;
        nfr = nfr + 1;
      end else if (nfr > 0) chk("row_gap", cyc - lr, rc);
      lr = cyc;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) failures = failures + 1;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic st_chk(input logic [3:0] exp);
    apb(1'b0, FTSS_OFF_STATUS, 32'h0000_0000);
    chk("state", {28'h0, rq[3:0]}, {28'h0, exp});
  endtask : st_chk
  task automatic wait_fr(input int n);
    int t;
    t = nfr + n;
    for (int j = 0; j < 5000 * n && nfr < t; j++) @(posedge pclk);
    if (nfr < t) failures = failures + 1;
  endtask : wait_fr
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // watchdog well beyond the expected run length
  initial begin
    #(5 * 100000);
    failures = failures + 1;
    test_done();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, run} = 5'h00;
    {paddr, pwdata, period, width} = '0;
    {failures, checks, cyc, nfr, st, lr, rows_c, ob_c, emb_c, tot, lv_c} = '0;
    rc = 20;
    fr = 24;
    ex = 7;
    void'($urandom(32'hcee2));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 7; i++) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("reset_value", rq, rsts[i]);
    end
    apb(1'b1, 8'h40, 32'h0000_0001);
    chk("unmapped", {31'h0, re}, 32'h0000_0001);
    apb(1'b1, FTSS_OFF_STATUS, 32'hFFFF_FFFF);
    st_chk(FTSS_ST_STBY);
    apb(1'b1, FTSS_OFF_ROWCLK, rc);
    apb(1'b1, FTSS_OFF_FRMROW, fr);
    apb(1'b1, FTSS_OFF_EXTRA, ex);
    apb(1'b1, FTSS_OFF_HEIGHT, 32'h0000_0004);
    apb(1'b1, FTSS_OFF_CTRL, 32'h0000_0001);
    wait_fr(2);
    chk("min_viol", {31'h0, mv}, 32'h0000_0001);
    chk("frame_len", per_l, fr * rc + ex);
    chk("rows", rows_l, fr);
    apb(1'b1, FTSS_OFF_FRMROW, 26);
    for (k = 0; k < 3; k++) begin
      wait_fr(1);
      chk("delayed_len", per_l, (k < 2 ? fr : 26) * rc + ex);
    end
    fr = 26;
    // black rows, embed bit and binning factors, each a frame pair late; skip factors act at once
    foreach (obq[k]) begin
      e = $urandom % 2;
      vb = 1 + $urandom % 3;
      hb = 1 + $urandom % 3;
      apb(1'b1, FTSS_OFF_BLANK, (32'(FTSS_IDLE_MIN) << 16) | (e << 8) | (obq[k] << 4));
      apb(1'b1, FTSS_OFF_SUBS, (vb << 6) | (hb << 4) | (1 + $urandom % 3));
      wait_fr(3);
      chk("ob_clocks", ob_l, obq[k] * rc);
      chk("embed_clocks", emb_l, e * 2 * rc);
      chk("line_clocks", lv_l, (fr - obq[k] - 8) * rc);
      chk("row_group", {30'h0, rgrp}, vb - 1);
      chk("pix_group", {30'h0, pgrp}, hb - 1);
      chk("skip_len", per_l, fr * rc + ex);
    end
    apb(1'b1, FTSS_OFF_CTRL, 32'h0000_0000);
    for (i = 0; i < 2000 && u_link.frame_active !== 1'b0; i++) @(posedge pclk);
    chk("last_rows", rows_c, fr);
    st_chk(FTSS_ST_STBY);
    apb(1'b1, FTSS_OFF_CTRL, 32'h0000_0004);
    apb(1'b1, FTSS_OFF_CTRL, 32'h0000_0006);
    apb(1'b1, FTSS_OFF_CTRL, 32'h0000_0007);
    s0 = tot;
    sp = sptr;
    repeat (40) @(posedge pclk);
    chk("halted", tot, s0);
    chk("read_ptr", {16'h0, rptr}, 32'h0000_0000);
    chk("shut_ptr", {16'h0, sptr}, sp);
    st_chk(FTSS_ST_WAIT);
    width <= 8'(3 + $urandom % 4);
    period <= fr * rc + ex + 60;
    run <= 1'b1;
    wait_fr(3);
    chk("slave_len", per_l, fr * rc + ex + 60);
    period <= fr * rc + ex + 6;
    wait_fr(3);
    chk("ignored_len", per_l, 2 * (fr * rc + ex + 6));
    test_done();
  end
endmodule : tb_top
`default_nettype wire
